// ---- bench/flash_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host controller model on the far side of the flash pins
module flash_host_model (
	input wire logic ref_clk_in,
	input wire logic link_run_in,
	output logic sel_a_n_out,
	output logic sel_b_n_out,
	output logic strobe_n_out,
	output logic gate_n_out,
	output logic we_n_out,
	output logic flash_clk_out,
	output logic [flash_pins_pkg::ADDR_W-1:0] addr_out,
	output logic [flash_pins_pkg::DATA_W-1:0] data_out
);
	// everything deselected and idle at time zero
	initial begin
		{sel_a_n_out, sel_b_n_out, strobe_n_out, gate_n_out, we_n_out} = 5'h1f;
		addr_out = '0;
		data_out = '0;
	end
	// burst clock toggles only within frames, unrelated in phase
	initial begin
		flash_clk_out = 1'h0;
		#7;
		forever #100 flash_clk_out = link_run_in ? ~flash_clk_out : 1'h0;
	end
	// hold one pin pattern for n core clocks; write data rides the strobe
	task automatic drive(input logic [4:0] p, input logic [flash_pins_pkg::ADDR_W-1:0] a,
			input logic [flash_pins_pkg::DATA_W-1:0] d, input int n);
		@(posedge ref_clk_in);
		{sel_a_n_out, sel_b_n_out, strobe_n_out, gate_n_out, we_n_out} <= p;
		addr_out <= a;
		data_out <= d;
		repeat (n - 1) @(posedge ref_clk_in);
	endtask : drive
	// deselect and drive the inverted address and data so no stale value lingers
	task automatic idle(input int n);
		drive(5'h1f, ~addr_out, ~data_out, n);
	endtask : idle
endmodule : flash_host_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk_in = 1'h0, rst_n_in = 1'h0, link_run = 1'h0, flash_clk_in;
	logic die_pair_a_select_n_in, die_pair_b_select_n_in, out_gate_n_in, write_strobe_n_in;
	logic addr_latch_strobe_n_in, lockdown_guard_n_in = 1'h0, sync_mode_req_in = 1'h0;
	logic array_data_valid_in = 1'h0, unlock_req_in = 1'h0, block_locked_down_in = 1'h0;
	logic [flash_pins_pkg::ADDR_W-1:0] addr_in, read_addr_out, write_addr_out;
	logic [flash_pins_pkg::DATA_W-1:0] dq_in, dq_out, write_data_out;
	logic [flash_pins_pkg::DATA_W-1:0] read_config_reg_in = '0, array_data_in = '0;
	logic [1:0] stack_mode_in = 2'h0;
	logic [flash_pins_pkg::DIES-1:0] die_select_out, ex;
	logic dq_oe_n_out, wait_out, wait_oe_n_out, standby_out, sync_read_active_out;
	logic burst_start_out, write_pulse_out, lockdown_override_out, unlock_grant_out;
	logic unlock_reject_out;
	logic [31:0] r, q;
	int failures = 0, tests_run = 0, seed = 32'h914b, wr_cnt = 0, bs_cnt = 0, n, sel;

	always #12.5 ref_clk_in = ~ref_clk_in;

	flash_host_model host_u (.ref_clk_in, .link_run_in(link_run),
		.sel_a_n_out(die_pair_a_select_n_in), .sel_b_n_out(die_pair_b_select_n_in),
		.strobe_n_out(addr_latch_strobe_n_in), .gate_n_out(out_gate_n_in),
		.we_n_out(write_strobe_n_in), .flash_clk_out(flash_clk_in), .addr_out(addr_in),
		.data_out(dq_in));

	flash_bus_pins_die_select dut_u (.ref_clk_in, .rst_n_in, .flash_clk_in,
		.addr_latch_strobe_n_in, .die_pair_a_select_n_in, .die_pair_b_select_n_in,
		.out_gate_n_in, .write_strobe_n_in, .lockdown_guard_n_in, .addr_in, .dq_in,
		.stack_mode_in, .sync_mode_req_in, .read_config_reg_in, .array_data_in,
		.array_data_valid_in, .unlock_req_in, .block_locked_down_in, .dq_out, .dq_oe_n_out,
		.wait_out, .wait_oe_n_out, .die_select_out, .standby_out, .sync_read_active_out,
		.read_addr_out, .burst_start_out, .write_pulse_out, .write_addr_out, .write_data_out,
		.lockdown_override_out, .unlock_grant_out, .unlock_reject_out);

	// count one-cycle pulses
	always @(posedge ref_clk_in) begin
		wr_cnt <= wr_cnt + int'(write_pulse_out === 1'h1);
		bs_cnt <= bs_cnt + int'(burst_start_out === 1'h1);
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one-hot die expected from stack shape, selects and top address bits
	function automatic logic [3:0] exp_dies(logic [1:0] s, logic a_n, logic b_n, logic [25:0] a);
		case (s)
			2'h0: return {3'h0, ~a_n};
			2'h1: return {2'h0, ~a_n & a[25], ~a_n & ~a[25]};
			2'h2: return {2'h0, ~a_n & a[24], ~a_n & ~a[24]};
			default: return {~b_n & a[24], ~b_n & ~a[24], ~a_n & a[24], ~a_n & ~a[24]};
		endcase
	endfunction : exp_dies

	// write cycle: strobe low, then rise with address and data held
	task automatic wr(input logic [4:0] p, input logic [25:0] a, input logic [15:0] d);
		host_u.drive(p, a, d, 5);
		host_u.drive(p | 5'h01, a, d, 5);
		host_u.idle(5);
	endtask : wr

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// cut a hang short
	initial begin
		#500000;
		failures++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge ref_clk_in);
		#1 check("reset outs", 9'h1c0, {dq_oe_n_out, wait_oe_n_out, standby_out, die_select_out,
			sync_read_active_out, write_pulse_out});
		@(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		host_u.idle(4);
		// random selects, stack shapes, gate, write strobe, polarity and data validity
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			q = $random(seed);
			sel = r[9:8] % 3;
			stack_mode_in <= r[1:0];
			sync_mode_req_in <= r[2];
			array_data_valid_in <= r[3];
			read_config_reg_in <= r[31:16];
			array_data_in <= q[31:16];
			host_u.drive({sel != 1, sel != 2, 1'h1, r[4], r[5]}, q[25:0], r[25:10], 5);
			#1 ex = exp_dies(r[1:0], sel != 1, sel != 2, q[25:0]);
			check("die_select", ex, die_select_out);
			check("standby", !(|ex), standby_out);
			check("dq_oe_n", !(|ex && !r[4] && r[5]), dq_oe_n_out);
			check("wait_oe_n", !(|ex && !r[4]), wait_oe_n_out);
			check("dq_out", q[31:16], dq_out);
			check("sync active", r[2], sync_read_active_out);
			if (|ex && !r[4])
				check("wait", (r[2] && r[5] && !r[3]) == r[26], wait_out);
		end
		host_u.idle(4);
		// accepted write, write with nothing selected, write held in reset
		n = wr_cnt;
		wr(5'h0e, q[25:0], r[15:0]);
		check("write pulses", n + 1, wr_cnt);
		check("write addr", q[25:0], write_addr_out);
		check("write data", r[15:0], write_data_out);
		wr(5'h1e, r[25:0], q[15:0]);
		check("unselected write", n + 1, wr_cnt);
		rst_n_in <= 1'h0;
		wr(5'h0e, r[25:0], q[15:0]);
		check("write in reset", n + 1, wr_cnt);
		check("write addr in reset", 26'h0, write_addr_out);
		rst_n_in <= 1'h1;
		sync_mode_req_in <= 1'h0;
		host_u.idle(4);
		// asynchronous: flow while strobe low, frozen once it rises
		host_u.drive(5'h09, 26'h1234567, '0, 5);
		host_u.drive(5'h0d, 26'h1234567, '0, 5);
		host_u.drive(5'h0d, 26'h2abcdef, '0, 5);
		check("async addr", 26'h1234567, read_addr_out);
		// synchronous: capture on strobe rise, then on second link clock rise, the first coinciding with strobe fall
		sync_mode_req_in <= 1'h1;
		n = bs_cnt;
		host_u.drive(5'h09, 26'h0155aa3, '0, 5);
		host_u.drive(5'h0d, 26'h0155aa3, '0, 5);
		#1 check("rise capture", n + 1, bs_cnt);
		check("rise addr", 26'h0155aa3, read_addr_out);
		link_run <= 1'h1;
		host_u.drive(5'h09, 26'h3c0ff0e, '0, 20);
		host_u.drive(5'h09, 26'h0000111, '0, 20);
		#1 check("clock capture", n + 2, bs_cnt);
		check("clock addr", 26'h3c0ff0e, read_addr_out);
		link_run <= 1'h0;
		host_u.idle(5);
		// unlock answers for every lock and guard combination
		for (int k = 0; k < 4; k++) begin
			lockdown_guard_n_in <= k[1];
			repeat (5) @(posedge ref_clk_in);
			unlock_req_in <= 1'h1;
			block_locked_down_in <= k[0];
			@(posedge ref_clk_in);
			unlock_req_in <= 1'h0;
			#1 check("unlock", (k[0] && !k[1]) ? 2'h1 : 2'h2, {unlock_grant_out, unlock_reject_out});
			check("override", k[1], lockdown_override_out);
		end
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire

// ---- common/flash_pins_pkg.sv ----
package flash_pins_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int DIES = 4;
	localparam int WAIT_POL_BIT = 10;
	localparam int DIE_ADDR_TOP_BIT = 25;
	localparam int DIE_ADDR_HI_BIT = 24;
	// pin bundle layout entering the synchroniser
	localparam int PIN_W = 7 + ADDR_W + DATA_W;
	// stack configurations
	localparam logic [1:0] STACK_SINGLE = 2'h0;
	localparam logic [1:0] STACK_GRID_PAIR = 2'h1;
	localparam logic [1:0] STACK_QUAD_PAIR = 2'h2;
	localparam logic [1:0] STACK_QUAD_FOUR = 2'h3;
	// reset values
	localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
	localparam logic [ADDR_W-1:0] RST_ADDR = 26'h0000000;
	localparam logic [DIES-1:0] RST_DIE_SEL = 4'h0;
	typedef enum logic {RD_ASYNC, RD_SYNC} read_mode_e;
	typedef enum logic [1:0] {ADR_IDLE, ADR_ARMED, ADR_HELD} addr_state_e;
endpackage : flash_pins_pkg

// ---- core/flash_bus_pins_die_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_bus_pins_die_select (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic flash_clk_in,
	input wire logic addr_latch_strobe_n_in,
	input wire logic die_pair_a_select_n_in,
	input wire logic die_pair_b_select_n_in,
	input wire logic out_gate_n_in,
	input wire logic write_strobe_n_in,
	input wire logic lockdown_guard_n_in,
	input wire logic [flash_pins_pkg::ADDR_W-1:0] addr_in,
	input wire logic [flash_pins_pkg::DATA_W-1:0] dq_in,
	input wire logic [1:0] stack_mode_in,
	input wire logic sync_mode_req_in,
	input wire logic [flash_pins_pkg::DATA_W-1:0] read_config_reg_in,
	input wire logic [flash_pins_pkg::DATA_W-1:0] array_data_in,
	input wire logic array_data_valid_in,
	input wire logic unlock_req_in,
	input wire logic block_locked_down_in,
	output logic [flash_pins_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_n_out,
	output logic wait_out,
	output logic wait_oe_n_out,
	output logic [flash_pins_pkg::DIES-1:0] die_select_out,
	output logic standby_out,
	output logic sync_read_active_out,
	output logic [flash_pins_pkg::ADDR_W-1:0] read_addr_out,
	output logic burst_start_out,
	output logic write_pulse_out,
	output logic [flash_pins_pkg::ADDR_W-1:0] write_addr_out,
	output logic [flash_pins_pkg::DATA_W-1:0] write_data_out,
	output logic lockdown_override_out,
	output logic unlock_grant_out,
	output logic unlock_reject_out
);
	logic [flash_pins_pkg::PIN_W-1:0] pins_s;
	logic fclk_s, als_n_s, cs_a_n_s, cs_b_n_s, oe_n_s, we_n_s, wp_n_s;
	logic [flash_pins_pkg::ADDR_W-1:0] addr_s;
	logic [flash_pins_pkg::DATA_W-1:0] dq_s;
	logic fclk_prev_q, als_prev_q, we_prev_q;
	logic fclk_rise, als_rise, als_fall, we_rise;
	logic [flash_pins_pkg::DIES-1:0] die_sel_d, die_sel_q;
	logic selected, wait_pol;
	flash_pins_pkg::read_mode_e mode_q;
	flash_pins_pkg::addr_state_e adr_q;
	logic [flash_pins_pkg::ADDR_W-1:0] addr_q, waddr_q;
	logic [flash_pins_pkg::DATA_W-1:0] dq_q, wdata_q;
	logic dq_oe_n_q, wait_q, wait_oe_n_q, standby_q, burst_q, wpulse_q;
	logic override_q, grant_q, reject_q;
	logic sync_q;

	// all pins cross into the core clock together
	pin_sync2 #(.WIDTH(flash_pins_pkg::PIN_W)) u_pin_sync (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.pins_in({flash_clk_in, addr_latch_strobe_n_in, die_pair_a_select_n_in,
			die_pair_b_select_n_in, out_gate_n_in, write_strobe_n_in,
			lockdown_guard_n_in, addr_in, dq_in}),
		.pins_out(pins_s)
	);
	assign {fclk_s, als_n_s, cs_a_n_s, cs_b_n_s, oe_n_s, we_n_s, wp_n_s, addr_s, dq_s} = pins_s;

	// die decode from selects, stack shape and high address bits
	function automatic logic [flash_pins_pkg::DIES-1:0] die_decode(
		input logic [1:0] stack,
		input logic cs_a_n,
		input logic cs_b_n,
		input logic [flash_pins_pkg::ADDR_W-1:0] addr
	);
		logic top, hi;
		top = addr[flash_pins_pkg::DIE_ADDR_TOP_BIT];
		hi = addr[flash_pins_pkg::DIE_ADDR_HI_BIT];
		case (stack)
			flash_pins_pkg::STACK_SINGLE: die_decode = {3'h0, !cs_a_n};
			flash_pins_pkg::STACK_GRID_PAIR: die_decode = {2'h0, !cs_a_n && top, !cs_a_n && !top};
			flash_pins_pkg::STACK_QUAD_PAIR: die_decode = {2'h0, !cs_a_n && hi, !cs_a_n && !hi};
			flash_pins_pkg::STACK_QUAD_FOUR: die_decode = {!cs_b_n && hi, !cs_b_n && !hi,
				!cs_a_n && hi, !cs_a_n && !hi};
			default: die_decode = flash_pins_pkg::RST_DIE_SEL;
		endcase
	endfunction : die_decode

	assign die_sel_d = die_decode(stack_mode_in, cs_a_n_s, cs_b_n_s, addr_s);
	assign selected = |die_sel_d;
	assign wait_pol = read_config_reg_in[flash_pins_pkg::WAIT_POL_BIT];
	assign fclk_rise = fclk_s && !fclk_prev_q;
	assign als_rise = als_n_s && !als_prev_q;
	assign als_fall = !als_n_s && als_prev_q;
	assign we_rise = we_n_s && !we_prev_q;

	// edge history of the synchronised pins
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fclk_prev_q <= 1'b1;
			als_prev_q <= 1'b1;
			we_prev_q <= 1'b1;
		end else begin
			fclk_prev_q <= fclk_s;
			als_prev_q <= als_n_s;
			we_prev_q <= we_n_s;
		end
	end

	// die selection and standby
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			die_sel_q <= flash_pins_pkg::RST_DIE_SEL;
			standby_q <= 1'b1;
		end else begin
			die_sel_q <= die_sel_d;
			standby_q <= !selected;
		end
	end

	// read mode, asynchronous array after reset
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q <= flash_pins_pkg::RD_ASYNC;
			sync_q <= 1'b0;
		end else begin
			sync_q <= sync_mode_req_in; // flop copy of the mode, next state is the request
			case (mode_q)
				flash_pins_pkg::RD_ASYNC: if (sync_mode_req_in) mode_q <= flash_pins_pkg::RD_SYNC;
				flash_pins_pkg::RD_SYNC: if (!sync_mode_req_in) mode_q <= flash_pins_pkg::RD_ASYNC;
				default: mode_q <= flash_pins_pkg::RD_ASYNC;
			endcase
		end
	end

	// address capture for both read modes
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			adr_q <= flash_pins_pkg::ADR_IDLE;
			addr_q <= flash_pins_pkg::RST_ADDR;
			burst_q <= 1'b0;
		end else begin
			burst_q <= 1'b0;
			case (adr_q)
				flash_pins_pkg::ADR_IDLE: begin
					if (!als_n_s && mode_q == flash_pins_pkg::RD_ASYNC) begin
						addr_q <= addr_s;
					end else if (als_fall && mode_q == flash_pins_pkg::RD_SYNC) begin
						adr_q <= flash_pins_pkg::ADR_ARMED;
					end
				end
				flash_pins_pkg::ADR_ARMED: begin
					if (als_rise || (fclk_rise && !als_n_s)) begin
						addr_q <= addr_s;
						burst_q <= 1'b1;
						adr_q <= flash_pins_pkg::ADR_HELD;
					end
				end
				flash_pins_pkg::ADR_HELD: begin
					if (als_n_s) adr_q <= flash_pins_pkg::ADR_IDLE;
				end
				default: adr_q <= flash_pins_pkg::ADR_IDLE;
			endcase
		end
	end

	// data drivers follow output gate and selection
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dq_q <= flash_pins_pkg::RST_DATA;
			dq_oe_n_q <= 1'b1;
		end else begin
			dq_q <= array_data_in;
			dq_oe_n_q <= !(selected && !oe_n_s && we_n_s);
		end
	end

	// wait level and its driver
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_q <= 1'b0;
			wait_oe_n_q <= 1'b1;
		end else begin
			wait_oe_n_q <= !(selected && !oe_n_s);
			if (mode_q == flash_pins_pkg::RD_SYNC && we_n_s && !array_data_valid_in) begin
				wait_q <= wait_pol;
			end else begin
				wait_q <= !wait_pol;
			end
		end
	end

	// write capture on strobe rise, none while in reset
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wpulse_q <= 1'b0;
			waddr_q <= flash_pins_pkg::RST_ADDR;
			wdata_q <= flash_pins_pkg::RST_DATA;
		end else begin
			wpulse_q <= we_rise && selected;
			if (we_rise && selected) begin
				waddr_q <= addr_s;
				wdata_q <= dq_s;
			end
		end
	end

	// lock-down guard and unlock arbitration
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			override_q <= 1'b0;
			grant_q <= 1'b0;
			reject_q <= 1'b0;
		end else begin
			override_q <= wp_n_s;
			reject_q <= unlock_req_in && block_locked_down_in && !wp_n_s;
			grant_q <= unlock_req_in && !(block_locked_down_in && !wp_n_s);
		end
	end

	assign dq_out = dq_q;
	assign dq_oe_n_out = dq_oe_n_q;
	assign wait_out = wait_q;
	assign wait_oe_n_out = wait_oe_n_q;
	assign die_select_out = die_sel_q;
	assign standby_out = standby_q;
	assign sync_read_active_out = sync_q;
	assign read_addr_out = addr_q;
	assign burst_start_out = burst_q;
	assign write_pulse_out = wpulse_q;
	assign write_addr_out = waddr_q;
	assign write_data_out = wdata_q;
	assign lockdown_override_out = override_q;
	assign unlock_grant_out = grant_q;
	assign unlock_reject_out = reject_q;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_data_float_gate: assert property (oe_n_s |=> dq_oe_n_out)
		else $error("data driven while gate high");
	a_data_drive_read: assert property (selected && !oe_n_s && we_n_s |=> !dq_oe_n_out)
		else $error("data not driven during read");
	a_wait_float_idle: assert property ((!selected || oe_n_s) |=> wait_oe_n_out)
		else $error("wait driven while deselected or gated");
	a_wait_invalid_word: assert property (mode_q == flash_pins_pkg::RD_SYNC && we_n_s
		&& !array_data_valid_in |=> wait_out == $past(wait_pol))
		else $error("wait not asserted for invalid word");
	a_wait_async_quiet: assert property (mode_q == flash_pins_pkg::RD_ASYNC
		|=> wait_out != $past(wait_pol))
		else $error("wait asserted outside burst");
	a_write_latch_rise: assert property (we_rise && selected
		|=> write_pulse_out && write_addr_out == $past(addr_s) && write_data_out == $past(dq_s))
		else $error("write not latched on strobe rise");
	a_unlock_guard_low: assert property (unlock_req_in && block_locked_down_in && !wp_n_s
		|=> unlock_reject_out && !unlock_grant_out)
		else $error("locked-down block unlocked");
	a_guard_override: assert property (wp_n_s && unlock_req_in
		|=> lockdown_override_out && unlock_grant_out)
		else $error("guard high did not override");
	a_async_addr_flow: assert property (adr_q == flash_pins_pkg::ADR_IDLE && !als_n_s
		&& mode_q == flash_pins_pkg::RD_ASYNC |=> read_addr_out == $past(addr_s))
		else $error("address not flowing through");
	a_sync_clk_capture: assert property (adr_q == flash_pins_pkg::ADR_ARMED && fclk_rise && !als_n_s
		|=> burst_start_out && read_addr_out == $past(addr_s) ##1 !burst_start_out)
		else $error("sync address not captured");
	a_grid_die_two: assert property (stack_mode_in == flash_pins_pkg::STACK_GRID_PAIR && !cs_a_n_s
		&& addr_s[flash_pins_pkg::DIE_ADDR_TOP_BIT] |=> die_select_out == 4'h2)
		else $error("grid stack die two not selected");
	a_quad_die_four: assert property (stack_mode_in == flash_pins_pkg::STACK_QUAD_FOUR && cs_a_n_s
		&& !cs_b_n_s && addr_s[flash_pins_pkg::DIE_ADDR_HI_BIT] |=> die_select_out == 4'h8)
		else $error("quad stack die four not selected");
	a_standby_idle: assert property (!selected |=> standby_out && dq_oe_n_out && wait_oe_n_out)
		else $error("deselected die not idle");
endmodule : flash_bus_pins_die_select
`default_nettype wire

// ---- core/pin_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] pins_out
);
	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	// two flops per pin, first stage read only by the second
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage1_q <= '1;
			stage2_q <= '1;
		end else begin
			stage1_q <= pins_in;
			stage2_q <= stage1_q;
		end
	end

	assign pins_out = stage2_q;
endmodule : pin_sync2
`default_nettype wire
